// File: rtl/rsasd_cfg.svh
`ifndef RSASD_CFG_SVH
`define RSASD_CFG_SVH
// Clock rate in kHz and documented times
`define RSASD_CLK_KHZ        40000
`define RSASD_IDLE_S         30
`define RSASD_IDLE_CYC       (`RSASD_IDLE_S * `RSASD_CLK_KHZ * 1000)
`define RSASD_WAKE_US        100
`define RSASD_WAKE_CYC       ((`RSASD_WAKE_US * `RSASD_CLK_KHZ) / 1000)
`endif

// File: rtl/rsasd_pkg.sv
package rsasd_pkg;
    // Power state of the pumps and drivers
    typedef enum logic [1:0] {
        RSASD_SLEEP,
        RSASD_WAKE,
        RSASD_ACTIVE
    } rsasd_state_t;

    // Rail comparator results from the charge pump
    typedef struct packed {
        logic neg_below_3v;
        logic neg_below_4v;
    } rsasd_rail_t;
endpackage : rsasd_pkg

// File: rtl/rsasd_ctrl.sv
`include "rsasd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rsasd_ctrl
    import rsasd_pkg::*;
#(
    parameter int  N_RX      = 2,
    parameter int  N_TX      = 2,
    parameter int  IDLE_CYC  = `RSASD_IDLE_CYC,
    parameter int  WAKE_CYC  = `RSASD_WAKE_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [N_RX-1:0]   rx_valid_lvl,
    input  wire logic [N_RX-1:0]   rx_data,
    input  wire logic [N_TX-1:0]   tx_data,
    input  wire logic              force_awake_in,
    input  wire logic              force_sleep_n,
    input  wire rsasd_rail_t       rail,
    output logic                   signal_present,
    output logic                   supply_ready,
    output logic                   pump_en,
    output logic                   tx_oe_n
);
    localparam int CW = $clog2(IDLE_CYC + 1);

    logic [N_RX-1:0] rxv_s1, rxv_s2, rxd_s1, rxd_s2, rxd_d;
    logic [N_TX-1:0] txd_s1, txd_s2, txd_d;
    logic [1:0]      frc_s1, frc_s2;
    logic [1:0]      rail_s1, rail_s2;
    logic [CW-1:0]   idle_cnt;
    logic [CW-1:0]   wake_cnt;
    logic            edge_seen;
    logic            any_valid;
    logic            awake_f, sleep_nf;
    logic            want_on;
    rsasd_state_t    state;

    // Receiver level synchroniser; comparator outputs are asynchronous
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxv_s1 <= '0;
            rxv_s2 <= '0;
        end else begin
            rxv_s1 <= rx_valid_lvl;
            rxv_s2 <= rxv_s1;
        end
    end

    // Receiver data synchroniser for activity detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxd_s1 <= '0;
            rxd_s2 <= '0;
        end else begin
            rxd_s1 <= rx_data;
            rxd_s2 <= rxd_s1;
        end
    end

    // Transmitter input synchroniser for activity detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txd_s1 <= '0;
            txd_s2 <= '0;
        end else begin
            txd_s1 <= tx_data;
            txd_s2 <= txd_s1;
        end
    end

    // Force input synchroniser; bit 1 is awake, bit 0 is sleep_n
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frc_s1 <= 2'h0;
            frc_s2 <= 2'h0;
        end else begin
            frc_s1 <= {force_awake_in, force_sleep_n};
            frc_s2 <= frc_s1;
        end
    end

    // Rail comparator synchroniser; bit 1 is minus 3 V, bit 0 minus 4 V
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rail_s1 <= 2'h0;
            rail_s2 <= 2'h0;
        end else begin
            rail_s1 <= {rail.neg_below_3v, rail.neg_below_4v};
            rail_s2 <= rail_s1;
        end
    end

    // Delayed copies for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxd_d <= '0;
            txd_d <= '0;
        end else begin
            rxd_d <= rxd_s2;
            txd_d <= txd_s2;
        end
    end

    assign edge_seen = |(rxd_s2 ^ rxd_d) | |(txd_s2 ^ txd_d);
    assign any_valid = |rxv_s2;
    assign awake_f   = frc_s2[1];
    assign sleep_nf  = frc_s2[0];

    // Signal-present flag from receiver levels only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) signal_present <= 1'b0;
        else        signal_present <= any_valid;
    end

    // Inactivity timer, cleared by every edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt <= '0;
        end else if (edge_seen) begin
            idle_cnt <= '0;
        end else if (idle_cnt < CW'(IDLE_CYC)) begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    // Power decision: forced off, forced on, else automatic
    always_comb begin
        if (!sleep_nf) begin
            want_on = 1'b0;
        end else if (awake_f) begin
            want_on = 1'b1;
        end else begin
            want_on = edge_seen || (idle_cnt < CW'(IDLE_CYC));
        end
    end

    // Power state machine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= RSASD_SLEEP;
            wake_cnt <= '0;
        end else begin
            case (state)
                RSASD_SLEEP: begin
                    wake_cnt <= '0;
                    if (want_on) state <= RSASD_WAKE;
                end
                RSASD_WAKE: begin
                    if (!want_on) begin
                        state <= RSASD_SLEEP;
                    end else if (wake_cnt >= CW'(WAKE_CYC - 1) && rail_s2[1]) begin
                        state <= RSASD_ACTIVE;
                    end else if (wake_cnt < CW'(WAKE_CYC - 1)) begin
                        wake_cnt <= wake_cnt + 1'b1;
                    end
                end
                RSASD_ACTIVE: begin
                    if (!want_on) state <= RSASD_SLEEP;
                end
                default: state <= RSASD_SLEEP;
            endcase
        end
    end

    // Registered power outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pump_en      <= 1'b0;
            tx_oe_n      <= 1'b1;
            supply_ready <= 1'b0;
        end else begin
            pump_en      <= want_on;
            tx_oe_n      <= !(want_on && state == RSASD_ACTIVE);
            supply_ready <= want_on && state != RSASD_SLEEP && rail_s2[0];
        end
    end

    // Checks
    a_force_sleep_off: assert property (@(posedge clk) disable iff (!rst_n)
        !sleep_nf |=> tx_oe_n && !pump_en) else $error("drivers on while forced off");
    a_present_follows: assert property (@(posedge clk) disable iff (!rst_n)
        signal_present == $past(any_valid)) else $error("signal present wrong");
    a_force_on_pump: assert property (@(posedge clk) disable iff (!rst_n)
        sleep_nf && awake_f |=> pump_en) else $error("force awake ignored");
    a_edge_restart: assert property (@(posedge clk) disable iff (!rst_n)
        edge_seen |=> idle_cnt == '0) else $error("timer not restarted");
    a_idle_sleep: assert property (@(posedge clk) disable iff (!rst_n)
        sleep_nf && !awake_f && !edge_seen && idle_cnt == CW'(IDLE_CYC) |=> !pump_en)
        else $error("no sleep after idle");
    a_rail_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !tx_oe_n |-> $past(rail_s2[1], 2)) else $error("drivers on before rail");
    a_ready_low: assert property (@(posedge clk) disable iff (!rst_n)
        !pump_en |-> !supply_ready) else $error("ready high in shutdown");
    a_wake_edge: assert property (@(posedge clk) disable iff (!rst_n)
        sleep_nf && edge_seen |=> pump_en) else $error("edge did not wake");
    a_ready_rail: assert property (@(posedge clk) disable iff (!rst_n)
        supply_ready |-> $past(rail_s2[0])) else $error("ready without rail");

    // Cycles spent in wake-up; lets the exit-time check see the whole wait
    // even though wake_cnt itself saturates
    logic [CW-1:0] wake_age;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_age <= '0;
        end else if (state == RSASD_WAKE) begin
            wake_age <= wake_age + 1'b1;
        end else begin
            wake_age <= '0;
        end
    end

    // Drivers never reach active before the full wake time
    a_wake_exit: assert property (@(posedge clk) disable iff (!rst_n)
        state == RSASD_WAKE ##1 state == RSASD_ACTIVE
        |-> $past(wake_age) >= CW'(WAKE_CYC - 1))
        else $error("wake exit too early");

    // Drivers enabled only from the active state
    a_oe_active: assert property (@(posedge clk) disable iff (!rst_n)
        !tx_oe_n
        |-> $past(state) == RSASD_ACTIVE)
        else $error("drivers on outside active");

    // Wake counter starts fresh on every wake-up
    a_sleep_clears: assert property (@(posedge clk) disable iff (!rst_n)
        state == RSASD_SLEEP
        |=> wake_cnt == '0)
        else $error("wake count not cleared");

    // Automatic mode stays on while the quiet interval is short
    a_auto_on: assert property (@(posedge clk) disable iff (!rst_n)
        sleep_nf && !awake_f && idle_cnt < CW'(IDLE_CYC)
        |=> pump_en)
        else $error("automatic mode off too early");

    // Timer saturates at the idle limit and never wraps
    a_timer_cap: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1
        |-> idle_cnt <= CW'(IDLE_CYC))
        else $error("idle timer past limit");

    // Timer counts up by one while quiet
    a_timer_count: assert property (@(posedge clk) disable iff (!rst_n)
        !edge_seen && idle_cnt < CW'(IDLE_CYC)
        |=> idle_cnt == $past(idle_cnt) + 1'b1)
        else $error("idle timer did not count");

    // Signal-present still follows receivers while forced off
    a_present_forced: assert property (@(posedge clk) disable iff (!rst_n)
        !sleep_nf && any_valid
        |=> signal_present)
        else $error("signal present masked by force");

    // Shutdown drops ready and driver enable together with the pump
    a_ready_drop: assert property (@(posedge clk) disable iff (!rst_n)
        !want_on
        |=> !supply_ready && tx_oe_n)
        else $error("ready or drivers left on");

    // Forced off keeps ready low whatever the rail does
    a_force_ready: assert property (@(posedge clk) disable iff (!rst_n)
        !sleep_nf
        |=> !supply_ready)
        else $error("ready high while forced off");

    // Forced on leaves shutdown at once
    a_awake_level: assert property (@(posedge clk) disable iff (!rst_n)
        sleep_nf && awake_f
        |=> state != RSASD_SLEEP)
        else $error("forced on still asleep");

    // Full quiet interval in automatic mode returns to shutdown state
    a_idle_state: assert property (@(posedge clk) disable iff (!rst_n)
        sleep_nf && !awake_f && !edge_seen && idle_cnt == CW'(IDLE_CYC)
        |=> state == RSASD_SLEEP)
        else $error("state not asleep after idle");
endmodule : rsasd_ctrl
`default_nettype wire

// File: tb/rsasd_pump_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsasd_pump_model
    import rsasd_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      pump_en,
    input  wire logic      slow,
    output var rsasd_rail_t rail
);
    int cnt = 0;
    // Negative rail builds while pumping, falls to ground when stopped
    always_ff @(posedge clk) begin
        cnt <= pump_en ? cnt + 1 : 0;
    end
    // Slow mode models a heavily loaded rail
    assign rail.neg_below_3v = cnt >= (slow ? 60 : 3);
    assign rail.neg_below_4v = cnt >= (slow ? 64 : 5);
endmodule : rsasd_pump_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import rsasd_pkg::*;;
    logic        clk = 0, rst_n = 0, fa = 0, fs_n = 1, slow = 0;
    logic [1:0]  rxv = 0, rxd = 0, txd = 0;
    logic        sp, rdy, pen, oe_n;
    rsasd_rail_t rail;
    logic [3:0]  q[$];
    logic [31:0] seed = 32'h61ef4936;
    int          err_total = 0, n_compared = 0;
    event        ev;

    rsasd_ctrl #(.IDLE_CYC(200), .WAKE_CYC(10)) dut (
        .clk(clk), .rst_n(rst_n), .rx_valid_lvl(rxv), .rx_data(rxd), .tx_data(txd),
        .force_awake_in(fa), .force_sleep_n(fs_n), .rail(rail), .signal_present(sp),
        .supply_ready(rdy), .pump_en(pen), .tx_oe_n(oe_n));
    rsasd_pump_model pump (.clk(clk), .pump_en(pen), .slow(slow), .rail(rail));

    // Clock at 40 MHz
    initial begin
        forever #12.5 clk = ~clk;
    end

    // Next value of the random sequence
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    // Waits n edges, then notes {present, pump, oe_n, ready}
    task automatic chk(input int n, input logic [3:0] e);
        repeat (n) @(posedge clk);
        q.push_back(e);
        ->ev;
    endtask : chk

    task automatic summarize();
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    // Compares the outputs with the oldest note
    initial begin
        forever begin
            @(ev);
            #1;
            n_compared++;
            if ({sp, pen, oe_n, rdy} !== q[0]) begin
                err_total++;
                $display("ERROR outputs exp %b got %b", q[0], {sp, pen, oe_n, rdy});
            end
            void'(q.pop_front());
        end
    end

    // Cuts a hang short
    initial begin
        #100us;
        err_total++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        chk(40, 4'b0101);
        seed = xs(seed);
        @(posedge clk);
        fs_n <= 0;
        rxv  <= seed[1:0] | 2'b01;
        txd  <= seed[3:2] ^ 2'b10;
        chk(4, 4'b1010);
        rxv <= 2'b00;
        chk(4, 4'b0010);
        fs_n <= 1;
        fa   <= 1;
        chk(6, 4'b0110);
        chk(30, 4'b0101);
        fa  <= 0;
        txd <= ~txd;
        chk(150, 4'b0101);
        rxd <= ~rxd;
        chk(120, 4'b0101);
        chk(120, 4'b0010);
        slow   <= 1;
        rxd[1] <= ~rxd[1];
        chk(30, 4'b0110);
        chk(80, 4'b0101);
        fa   <= 0;
        fs_n <= 0;
        chk(4, 4'b0010);
        fa   <= 1;
        fs_n <= 1;
        chk(6, 4'b0110);
        @(posedge clk);
        summarize();
    end
endmodule : testbench
`default_nettype wire
